// file: hw/actuator_id_bank.sv
// Identification, date stamp and diagnostic fault register bank of a valve actuator.
//
// What this block does
// - 32-bit values span two registers, accessed whole in one function only.
// - Four read-only registers give application firmware major, minor, mod, build.
// - Four read-only registers give boot firmware major, minor, mod, build.
// - Three writable 32-bit date stamps count seconds since 2000, reset zero.
// - All register contents are unsigned integers.
// - Bit 15 set on memory fault with factory defaults restored.
// - Bit 14 set when stalled and stopped short of commanded position.
// - Bit 13 set when override contact closed and safe position reached.
// - Bit 12 set on system or watchdog fatal error with shutdown.
// - Bit 11 set when analog calibration entries mismatch measured signal.
// - Bit 10 set when calibrated travel distance is out of range.
// - Span under 4 mA sets bit 9, rejected, old calibration kept.
// - Bit 7 set when power was lost during a move.
// - Bit 6 set once span is calibrated and actuator ready.
// - Bit 5 set while position controller is active and ready.
// - Bit 4 set when signal at or below 3 mA or 1 V beyond loss timeout.
// - Bit 2 set once a serial command starts a calibrated move.
// - Bit 1 set once analog input exceeded 3 mA or 1 V.
// - Bit 0 set during 15 second startup window permitting span calibration.
`timescale 1ns/1ps
`include "actuator_id_regs.svh"

module actuator_id_bank
    import actuator_id_pkg::*;
#(
    parameter logic [15:0] APP_FW_MAJOR = 16'h0000,
    parameter logic [15:0] APP_FW_MINOR = 16'h0000,
    parameter logic [15:0] APP_FW_MOD = 16'h0000,
    parameter logic [15:0] APP_FW_BUILD = 16'h0000,
    parameter logic [15:0] BOOT_FW_MAJOR = 16'h0000,
    parameter logic [15:0] BOOT_FW_MINOR = 16'h0000,
    parameter logic [15:0] BOOT_FW_MOD = 16'h0000,
    parameter logic [15:0] BOOT_FW_BUILD = 16'h0000,
    parameter logic [31:0] STARTUP_CYCLES = 32'(64'(`START_WINDOW_S) * 64'(`CLK_HZ))
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire hreg_req_type req,
    output hreg_resp_type resp,
    input wire logic nvm_defaults_restored,
    input wire logic travel_stalled,
    input wire logic motor_stopped,
    input wire logic override_contact_closed,
    input wire logic at_safe_position,
    input wire logic fatal_shutdown,
    input wire logic ain_cal_mismatch,
    input wire logic travel_cal_out_of_range,
    input wire logic shutdown_while_moving,
    input wire logic span_calibrated,
    input wire logic controller_active,
    input wire logic serial_cmd_rx,
    input wire logic valve_moving,
    input wire logic ain_voltage_mode,
    input wire logic [15:0] ain_ua,
    input wire logic [15:0] ain_mv,
    input wire logic [31:0] los_timeout_cycles,
    input wire logic cal_apply,
    input wire span_type cal_new,
    output span_type span_active,
    output logic [15:0] fault_word
);

    // ------------------------------------------------------------------------
    // Register map lookup
    // ------------------------------------------------------------------------
    // Kind: 0 is a lone 16-bit word, 1 the high half of a pair, 2 the low half.
    // Pairs put the high word at the lower register number.
    function automatic word_info_type lookup(input bank_state_type s, input logic [15:0] a);
        word_info_type w;
        w = '{ok: 1'b1, kind: 2'd0, writable: 1'b0, value: 16'h0000};
        if (a == `ADDR_MOTOR_REVISION) begin
            w.kind = 2'd1;
            w.writable = 1'b1;
            w.value = s.motor_revision[31:16];
        end else if (a == `ADDR_MOTOR_REVISION + 16'h0001) begin
            w.kind = 2'd2;
            w.writable = 1'b1;
            w.value = s.motor_revision[15:0];
        end else if (a == `ADDR_BOARD_SERIAL) begin
            w.kind = 2'd1;
            w.writable = 1'b1;
            w.value = s.board_serial[31:16];
        end else if (a == `ADDR_BOARD_SERIAL + 16'h0001) begin
            w.kind = 2'd2;
            w.writable = 1'b1;
            w.value = s.board_serial[15:0];
        end else if (a == `ADDR_BOARD_REVISION) begin
            w.writable = 1'b1;
            w.value = s.board_revision;
        end else if (a == `ADDR_BOARD_REVISION_PAD) begin
            // The revision is 16 bits wide; its second slot reads zero.
            w.value = 16'h0000;
        end else if (a == `ADDR_APP_FW_MAJOR) begin
            w.value = APP_FW_MAJOR;
        end else if (a == `ADDR_APP_FW_MINOR) begin
            w.value = APP_FW_MINOR;
        end else if (a == `ADDR_APP_FW_MOD) begin
            w.value = APP_FW_MOD;
        end else if (a == `ADDR_APP_FW_BUILD) begin
            w.value = APP_FW_BUILD;
        end else if (a == `ADDR_BOOT_FW_MAJOR) begin
            w.value = BOOT_FW_MAJOR;
        end else if (a == `ADDR_BOOT_FW_MINOR) begin
            w.value = BOOT_FW_MINOR;
        end else if (a == `ADDR_BOOT_FW_MOD) begin
            w.value = BOOT_FW_MOD;
        end else if (a == `ADDR_BOOT_FW_BUILD) begin
            w.value = BOOT_FW_BUILD;
        end else if (a >= `ADDR_BOARD_TEST_DATE && a <= `ADDR_ASSEMBLY_DONE_DATE + 16'h0001) begin
            w.writable = 1'b1;
            w.kind = a[0] ? 2'd2 : 2'd1;
            w.value = a[0] ? s.dates[2'(a[2:1] - 2'd2)][15:0]
                           : s.dates[2'(a[2:1] - 2'd2)][31:16];
        end else if (a == `ADDR_DIAGNOSTIC_FAULT_WORD) begin
            w.value = s.fault;
        end else begin
            w.ok = 1'b0;
        end
        return w;
    endfunction

    // Store one 16-bit word; anything not writable is left untouched.
    function automatic bank_state_type put_word(input bank_state_type s, input logic [15:0] a,
                                                input logic [15:0] d);
        bank_state_type n;
        n = s;
        if (a == `ADDR_MOTOR_REVISION) begin
            n.motor_revision[31:16] = d;
        end else if (a == `ADDR_MOTOR_REVISION + 16'h0001) begin
            n.motor_revision[15:0] = d;
        end else if (a == `ADDR_BOARD_SERIAL) begin
            n.board_serial[31:16] = d;
        end else if (a == `ADDR_BOARD_SERIAL + 16'h0001) begin
            n.board_serial[15:0] = d;
        end else if (a == `ADDR_BOARD_REVISION) begin
            n.board_revision = d;
        end else if (a >= `ADDR_BOARD_TEST_DATE && a <= `ADDR_ASSEMBLY_DONE_DATE + 16'h0001) begin
            if (a[0]) begin
                n.dates[2'(a[2:1] - 2'd2)][15:0] = d;
            end else begin
                n.dates[2'(a[2:1] - 2'd2)][31:16] = d;
            end
        end
        return n;
    endfunction

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    bank_state_type state;
    bank_state_type next_state;
    word_info_type first_word;
    word_info_type second_word;
    logic signal_present;
    logic [15:0] span_diff;
    logic access_ok;

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        next_state = state;
        first_word = lookup(state, req.addr);
        second_word = lookup(state, req.addr + 16'h0001);
        signal_present = ain_voltage_mode ? (ain_mv > `SIGNAL_MIN_MV) : (ain_ua > `SIGNAL_MIN_UA);
        span_diff = (cal_new.open_ua > cal_new.close_ua) ? cal_new.open_ua - cal_new.close_ua
                                                         : cal_new.close_ua - cal_new.open_ua;
        access_ok = 1'b0;

        // A pair is taken only whole: a single-word access may not touch
        // either half, and a two-word access must start on the high half.
        next_state.resp.valid = req.valid;
        next_state.resp.rdata = 32'h0000_0000;
        next_state.resp.exc = `EXC_NONE;
        if (req.valid) begin
            if (req.qty == 2'd1) begin
                access_ok = first_word.ok && first_word.kind == 2'd0;
                next_state.resp.rdata = {16'h0000, first_word.value};
            end else if (req.qty == 2'd2) begin
                access_ok = first_word.ok && second_word.ok && first_word.kind != 2'd2
                            && second_word.kind != 2'd1;
                next_state.resp.rdata = {first_word.value, second_word.value};
            end
            if (req.qty != 2'd1 && req.qty != 2'd2) begin
                next_state.resp.exc = `EXC_BAD_QUANTITY;
                next_state.resp.rdata = 32'h0000_0000;
            end else if (!access_ok || (req.write && !first_word.writable)
                         || (req.write && req.qty == 2'd2 && !second_word.writable)) begin
                next_state.resp.exc = `EXC_BAD_ADDRESS;
                next_state.resp.rdata = 32'h0000_0000;
            end else if (req.write) begin
                next_state.resp.rdata = 32'h0000_0000;
                if (req.qty == 2'd1) begin
                    next_state = put_word(next_state, req.addr, req.wdata[15:0]);
                end else begin
                    next_state = put_word(next_state, req.addr, req.wdata[31:16]);
                    next_state = put_word(next_state, req.addr + 16'h0001, req.wdata[15:0]);
                end
            end
        end

        // Startup window counter stops at its end value.
        if (state.startup_cnt < STARTUP_CYCLES) begin
            next_state.startup_cnt = state.startup_cnt + 32'h0000_0001;
        end

        // Loss of signal timer restarts whenever the signal comes back.
        if (signal_present) begin
            next_state.los_cnt = 32'h0000_0000;
        end else if (state.los_cnt <= los_timeout_cycles) begin
            next_state.los_cnt = state.los_cnt + 32'h0000_0001;
        end

        if (signal_present) begin
            next_state.signal_seen = 1'b1;
        end

        // The command flag holds for the whole move it started.
        if (serial_cmd_rx && span_calibrated) begin
            next_state.cmd_seen = 1'b1;
        end else if (!valve_moving) begin
            next_state.cmd_seen = 1'b0;
        end

        // A narrow span is refused outright so a bad entry cannot wipe a good one.
        if (cal_apply) begin
            if (span_diff < `SPAN_MIN_UA) begin
                next_state.span_err = 1'b1;
            end else begin
                next_state.span_err = 1'b0;
                next_state.span = cal_new;
            end
        end

        next_state.fault = 16'h0000;
        next_state.fault[`FLT_NVM_DEFAULTS] = nvm_defaults_restored;
        next_state.fault[`FLT_STALL] = travel_stalled && motor_stopped;
        next_state.fault[`FLT_OVERRIDE] = override_contact_closed && at_safe_position;
        next_state.fault[`FLT_WATCHDOG] = fatal_shutdown;
        next_state.fault[`FLT_AIN_CAL] = ain_cal_mismatch;
        next_state.fault[`FLT_TRAVEL_CAL] = travel_cal_out_of_range;
        next_state.fault[`FLT_SPAN_CAL] = next_state.span_err;
        next_state.fault[`FLT_SHUTDOWN_MOVING] = shutdown_while_moving;
        next_state.fault[`FLT_SPAN_DONE] = span_calibrated;
        next_state.fault[`FLT_CTRL_ACTIVE] = controller_active;
        next_state.fault[`FLT_SIGNAL_LOST] = !signal_present
                                             && state.los_cnt > los_timeout_cycles;
        next_state.fault[`FLT_SERIAL_CMD] = next_state.cmd_seen;
        next_state.fault[`FLT_AIN_SEEN] = next_state.signal_seen;
        next_state.fault[`FLT_START_WINDOW] = state.startup_cnt < STARTUP_CYCLES;
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= '0;
            state.motor_revision <= `RESET_WORD32;
            state.board_serial <= `RESET_WORD32;
            state.board_revision <= `RESET_WORD16;
            state.dates <= {3{`RESET_WORD32}};
        end else begin
            state <= next_state;
        end
    end

    assign resp = state.resp;
    assign span_active = state.span;
    assign fault_word = state.fault;

endmodule // actuator_id_bank

// file: include/actuator_id_regs.svh
// Register numbers, fault word bit positions, reset values and timing figures.
`ifndef ACTUATOR_ID_REGS_SVH
`define ACTUATOR_ID_REGS_SVH

// ----------------------------------------------------------------------------
// Holding register numbers
// ----------------------------------------------------------------------------
`define ADDR_MOTOR_REVISION 16'h9CB6
`define ADDR_BOARD_SERIAL 16'h9CB8
`define ADDR_BOARD_REVISION 16'h9CBA
`define ADDR_BOARD_REVISION_PAD 16'h9CBB
`define ADDR_APP_FW_MAJOR 16'h9CBC
`define ADDR_APP_FW_MINOR 16'h9CBD
`define ADDR_APP_FW_MOD 16'h9CBE
`define ADDR_APP_FW_BUILD 16'h9CBF
`define ADDR_BOOT_FW_MAJOR 16'h9CC0
`define ADDR_BOOT_FW_MINOR 16'h9CC1
`define ADDR_BOOT_FW_MOD 16'h9CC2
`define ADDR_BOOT_FW_BUILD 16'h9CC3
`define ADDR_BOARD_TEST_DATE 16'h9CC4
`define ADDR_MOTOR_TEST_DATE 16'h9CC6
`define ADDR_ASSEMBLY_DONE_DATE 16'h9CC8
`define ADDR_DIAGNOSTIC_FAULT_WORD 16'h9CCA

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RESET_WORD32 32'h0000_0000
`define RESET_WORD16 16'h0000

// ----------------------------------------------------------------------------
// Fault word bit positions
// ----------------------------------------------------------------------------
`define FLT_NVM_DEFAULTS 15
`define FLT_STALL 14
`define FLT_OVERRIDE 13
`define FLT_WATCHDOG 12
`define FLT_AIN_CAL 11
`define FLT_TRAVEL_CAL 10
`define FLT_SPAN_CAL 9
`define FLT_UNUSED_HI 8
`define FLT_SHUTDOWN_MOVING 7
`define FLT_SPAN_DONE 6
`define FLT_CTRL_ACTIVE 5
`define FLT_SIGNAL_LOST 4
`define FLT_UNUSED_LO 3
`define FLT_SERIAL_CMD 2
`define FLT_AIN_SEEN 1
`define FLT_START_WINDOW 0

// ----------------------------------------------------------------------------
// Answer codes
// ----------------------------------------------------------------------------
`define EXC_NONE 8'h00
`define EXC_BAD_ADDRESS 8'h02
`define EXC_BAD_QUANTITY 8'h03

// ----------------------------------------------------------------------------
// Thresholds and timing
// ----------------------------------------------------------------------------
`define SIGNAL_MIN_UA 16'h0BB8
`define SIGNAL_MIN_MV 16'h03E8
`define SPAN_MIN_UA 16'h0FA0
`define START_WINDOW_S 15
`define CLK_HZ 200000000

`endif

// file: include/actuator_id_pkg.sv
// Types shared by the actuator identification and fault register bank.
package actuator_id_pkg;

    // ------------------------------------------------------------------------
    // Request and answer carriers
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
        logic [1:0] qty;
        logic [31:0] wdata;
    } hreg_req_type;

    typedef struct packed {
        logic valid;
        logic [7:0] exc;
        logic [31:0] rdata;
    } hreg_resp_type;

    typedef struct packed {
        logic ok;
        logic [1:0] kind;
        logic writable;
        logic [15:0] value;
    } word_info_type;

    typedef struct packed {
        logic [15:0] open_ua;
        logic [15:0] close_ua;
    } span_type;

    // ------------------------------------------------------------------------
    // Whole block state
    // ------------------------------------------------------------------------
    typedef struct packed {
        hreg_resp_type resp;
        logic [31:0] motor_revision;
        logic [31:0] board_serial;
        logic [15:0] board_revision;
        logic [2:0][31:0] dates;
        logic [31:0] startup_cnt;
        logic [31:0] los_cnt;
        logic signal_seen;
        logic cmd_seen;
        logic span_err;
        span_type span;
        logic [15:0] fault;
    } bank_state_type;

endpackage

// file: test/modbus_master_model.sv
// Modbus master model that issues one holding register function at a time.
`timescale 1ns/1ps
module modbus_master_model
    import actuator_id_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    output hreg_req_type req,
    input wire hreg_resp_type resp
);
    initial req = '0;
    // Both halves of a 32-bit value travel together in one function when q is 2.
    task automatic xfer(input logic wr, input logic [15:0] a, input logic [1:0] q,
        input logic [31:0] d, output logic [7:0] e, output logic [31:0] r);
        int n;
        n = 0;
        while (rst) begin
            @(posedge sys_clk);
        end
        @(posedge sys_clk);
        req <= '{valid: 1'b1, write: wr, addr: a, qty: q, wdata: d};
        @(posedge sys_clk);
        // Released fields show the inverse so a stale value cannot pass.
        req <= '{valid: 1'b0, write: ~wr, addr: ~a, qty: ~q, wdata: ~d};
        #1;
        while (resp.valid !== 1'b1 && n < 4) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        e = (resp.valid === 1'b1) ? resp.exc : 8'hFF;
        r = resp.rdata;
    endtask
endmodule // modbus_master_model

// file: test/actuator_id_checker.sv
// Concurrent checks on the ports of the actuator register bank.
`timescale 1ns/1ps
`include "actuator_id_regs.svh"
module actuator_id_checker
    import actuator_id_pkg::*;
#(
    parameter logic [31:0] STARTUP_CYCLES = 32'h64
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire hreg_req_type req,
    input wire hreg_resp_type resp,
    input wire logic travel_stalled,
    input wire logic motor_stopped,
    input wire logic override_contact_closed,
    input wire logic at_safe_position,
    input wire logic cal_apply,
    input wire span_type cal_new,
    input wire span_type span_active,
    input wire logic [15:0] fault_word
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [31:0] since_reset;
    logic narrow;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            since_reset <= 32'h0;
        end else if (since_reset != 32'hFFFFFFFF) begin
            since_reset <= since_reset + 32'h1;
        end
    end
    assign narrow = ((cal_new.open_ua > cal_new.close_ua) ? cal_new.open_ua - cal_new.close_ua
        : cal_new.close_ua - cal_new.open_ua) < `SPAN_MIN_UA;
    a_answer_next_cycle: assert property (req.valid |=> resp.valid)
        else $error("no answer one cycle after a request");
    a_no_spurious_answer: assert property (!req.valid |=> !resp.valid)
        else $error("answer without a request");
    a_bad_quantity: assert property (req.valid && (req.qty == 2'h0 || req.qty == 2'h3)
        |=> resp.exc == `EXC_BAD_QUANTITY)
        else $error("bad quantity not refused");
    a_ro_write_refused: assert property (req.valid && req.write && req.qty inside {2'h1, 2'h2}
        && req.addr inside {[16'h9CBC:16'h9CC3], 16'h9CCA} |=> resp.exc == `EXC_BAD_ADDRESS)
        else $error("write to read-only word accepted");
    a_unused_bits_zero: assert property (!fault_word[8] && !fault_word[3])
        else $error("unused fault bit set");
    a_stall_follows: assert property (fault_word[14] == $past(travel_stalled && motor_stopped))
        else $error("stall flag does not follow its source");
    a_override_follows: assert property (override_contact_closed && at_safe_position
        |=> fault_word[13])
        else $error("override flag not set");
    a_span_reject: assert property (cal_apply && narrow
        |=> $stable(span_active) ##[0:1] fault_word[9])
        else $error("narrow span not rejected");
    a_span_accept: assert property (cal_apply && !narrow
        |=> span_active == $past(cal_new) ##[0:1] !fault_word[9])
        else $error("wide span not accepted");
    a_startup_window: assert property (since_reset >= 32'h2
        && since_reset <= STARTUP_CYCLES - 32'h2 |-> fault_word[0])
        else $error("startup flag low inside window");
    a_startup_ends: assert property (since_reset >= STARTUP_CYCLES + 32'h3 |-> !fault_word[0])
        else $error("startup flag high after window");
    c_span_rejected: cover property (cal_apply && narrow);
    c_write_taken: cover property (req.valid && req.write);
    c_window_closed: cover property ($fell(fault_word[0]));
endmodule // actuator_id_checker

bind actuator_id_bank actuator_id_checker #(.STARTUP_CYCLES(STARTUP_CYCLES)) i_checker (
    .sys_clk(sys_clk), .rst(rst), .req(req), .resp(resp), .travel_stalled(travel_stalled),
    .motor_stopped(motor_stopped), .override_contact_closed(override_contact_closed),
    .at_safe_position(at_safe_position), .cal_apply(cal_apply), .cal_new(cal_new),
    .span_active(span_active), .fault_word(fault_word));

// file: test/testbench.sv
// Self-checking testbench for the actuator register bank.
`timescale 1ns/1ps
`include "actuator_id_regs.svh"
module testbench
    import actuator_id_pkg::*;
;
    localparam logic [15:0] FW [8] = '{16'h0001, 16'h0203, 16'h0405, 16'hFFFF,
        16'h8000, 16'h0A0B, 16'h0C0D, 16'h7FFF};
    localparam logic [15:0] PAIRS [5] = '{`ADDR_MOTOR_REVISION, `ADDR_BOARD_SERIAL,
        `ADDR_BOARD_TEST_DATE, `ADDR_MOTOR_TEST_DATE, `ADDR_ASSEMBLY_DONE_DATE};
    localparam logic [11:0] LV [14] = '{12'h001, 12'h002, 12'h004, 12'h006, 12'h008, 12'h010,
        12'h018, 12'h020, 12'h040, 12'h080, 12'h100, 12'h200, 12'h400, 12'hFFF};
    logic sys_clk, rst, serial_cmd_rx, ain_voltage_mode, cal_apply;
    logic [11:0] lv;
    logic [15:0] ain_ua, ain_mv, fault_word;
    logic [7:0] exc;
    logic [31:0] rdata;
    hreg_req_type req;
    hreg_resp_type resp;
    span_type cal_new, span_active;
    int bad_count, cmp_count, cycles;

    modbus_master_model i_master (.sys_clk(sys_clk), .rst(rst), .req(req), .resp(resp));
    actuator_id_bank #(.APP_FW_MAJOR(FW[0]), .APP_FW_MINOR(FW[1]), .APP_FW_MOD(FW[2]),
        .APP_FW_BUILD(FW[3]), .BOOT_FW_MAJOR(FW[4]), .BOOT_FW_MINOR(FW[5]), .BOOT_FW_MOD(FW[6]),
        .BOOT_FW_BUILD(FW[7]), .STARTUP_CYCLES(32'h64)) i_dut (
        .sys_clk(sys_clk), .rst(rst), .req(req), .resp(resp), .nvm_defaults_restored(lv[0]),
        .travel_stalled(lv[1]), .motor_stopped(lv[2]), .override_contact_closed(lv[3]),
        .at_safe_position(lv[4]), .fatal_shutdown(lv[5]), .ain_cal_mismatch(lv[6]),
        .travel_cal_out_of_range(lv[7]), .shutdown_while_moving(lv[8]), .span_calibrated(lv[9]),
        .controller_active(lv[10]), .serial_cmd_rx(serial_cmd_rx), .valve_moving(lv[11]),
        .ain_voltage_mode(ain_voltage_mode), .ain_ua(ain_ua), .ain_mv(ain_mv),
        .los_timeout_cycles(32'hA), .cal_apply(cal_apply), .cal_new(cal_new),
        .span_active(span_active), .fault_word(fault_word));

    // ------------------------------------------------------------------
    // Access and compare tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [15:0] a, input logic [1:0] q, input logic [31:0] x,
        input logic [7:0] e);
        i_master.xfer(1'b0, a, q, 32'h0, exc, rdata);
        check({24'h0, exc}, {24'h0, e});
        check(rdata, x);
    endtask
    task automatic wr(input logic [15:0] a, input logic [1:0] q, input logic [31:0] d,
        input logic [7:0] e);
        i_master.xfer(1'b1, a, q, d, exc, rdata);
        check({24'h0, exc}, {24'h0, e});
    endtask
    task automatic fault_is(input logic [15:0] m, input logic [15:0] x);
        repeat (2) @(posedge sys_clk);
        i_master.xfer(1'b0, `ADDR_DIAGNOSTIC_FAULT_WORD, 2'h1, 32'h0, exc, rdata);
        check(rdata & {16'h0, m}, {16'h0, x});
    endtask
    task automatic apply(input logic [15:0] o, input logic [15:0] c);
        @(posedge sys_clk);
        cal_new <= '{open_ua: o, close_ua: c};
        cal_apply <= 1'b1;
        @(posedge sys_clk);
        cal_apply <= 1'b0;
    endtask
    function automatic logic [15:0] exp_fault(input logic [11:0] v);
        return {v[0], v[1] & v[2], v[3] & v[4], v[5], v[6], v[7], 2'h0, v[8], v[9], v[10], 5'h0};
    endfunction
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Clock, timeout and test sequence
    // ------------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            $display("[ERR] %0t run did not finish", $time);
            conclude();
        end
    end
    initial begin
        {rst, lv, serial_cmd_rx, ain_voltage_mode, ain_ua, ain_mv} = {1'b1, 46'h0};
        {cal_apply, cal_new, bad_count, cmp_count, cycles} = '0;
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        fault_is(16'h0001, 16'h0001);
        for (int i = 0; i < 8; i++) rd(16'h9CBC + 16'(i), 2'h1, {16'h0, FW[i]}, `EXC_NONE);
        wr(`ADDR_APP_FW_MAJOR, 2'h1, 32'h1234, `EXC_BAD_ADDRESS);
        wr(`ADDR_BOOT_FW_BUILD, 2'h1, 32'h1234, `EXC_BAD_ADDRESS);
        rd(`ADDR_BOARD_REVISION, 2'h1, 32'h0, `EXC_NONE);
        wr(`ADDR_BOARD_REVISION, 2'h1, 32'hFFFF, `EXC_NONE);
        rd(`ADDR_BOARD_REVISION, 2'h1, 32'hFFFF, `EXC_NONE);
        for (int i = 0; i < 5; i++) begin
            rd(PAIRS[i], 2'h2, 32'h0, `EXC_NONE);
            wr(PAIRS[i], 2'h2, 32'hFFFE8001 + 32'(i), `EXC_NONE);
            wr(PAIRS[i], 2'h1, 32'h5555, `EXC_BAD_ADDRESS);
            wr(PAIRS[i] + 16'h1, 2'h2, 32'h5555, `EXC_BAD_ADDRESS);
            rd(PAIRS[i] + 16'h1, 2'h1, 32'h0, `EXC_BAD_ADDRESS);
            rd(PAIRS[i], 2'h2, 32'hFFFE8001 + 32'(i), `EXC_NONE);
        end
        rd(16'h9CB5, 2'h1, 32'h0, `EXC_BAD_ADDRESS);
        rd(`ADDR_BOARD_SERIAL, 2'h3, 32'h0, `EXC_BAD_QUANTITY);
        rd(`ADDR_BOARD_SERIAL, 2'h0, 32'h0, `EXC_BAD_QUANTITY);
        wr(`ADDR_DIAGNOSTIC_FAULT_WORD, 2'h1, 32'hFFFF, `EXC_BAD_ADDRESS);
        fault_is(16'h0001, 16'h0000);
        for (int i = 0; i < 14; i++) begin
            @(posedge sys_clk);
            lv <= LV[i];
            fault_is(16'hFDE8, exp_fault(LV[i]));
        end
        @(posedge sys_clk);
        lv <= 12'h000;
        ain_ua <= 16'h0BB9;
        fault_is(16'h0012, 16'h0002);
        @(posedge sys_clk);
        ain_ua <= 16'h0BB8;
        fault_is(16'h0012, 16'h0002);
        repeat (12) @(posedge sys_clk);
        fault_is(16'h0012, 16'h0012);
        @(posedge sys_clk);
        {ain_voltage_mode, ain_mv} <= {1'b1, 16'h03E9};
        fault_is(16'h0012, 16'h0002);
        @(posedge sys_clk);
        lv <= 12'hA00;
        serial_cmd_rx <= 1'b1;
        @(posedge sys_clk);
        serial_cmd_rx <= 1'b0;
        fault_is(16'h0004, 16'h0004);
        @(posedge sys_clk);
        lv <= 12'h000;
        fault_is(16'h0004, 16'h0000);
        apply(16'h4E20, 16'h0FA0);
        fault_is(16'h0200, 16'h0000);
        check(span_active, 32'h4E200FA0);
        apply(16'h1770, 16'h0FA0);
        fault_is(16'h0200, 16'h0200);
        check(span_active, 32'h4E200FA0);
        apply(16'h1F40, 16'h0FA0);
        fault_is(16'h0200, 16'h0000);
        check(span_active, 32'h1F400FA0);
        @(posedge sys_clk);
        // Reset with the input signal dropped so the sticky signal flag must come back cleared.
        {rst, ain_voltage_mode} <= 2'b10;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        rd(`ADDR_ASSEMBLY_DONE_DATE, 2'h2, 32'h0, `EXC_NONE);
        fault_is(16'h0003, 16'h0001);
        conclude();
    end
endmodule // testbench
